// [scd_pkg.sv]
// Package: opcodes, register map, reset values and timing for the decoder
package scd_pkg;

	// ****************************************************************
	// Command opcodes
	// ****************************************************************
	localparam logic [7:0] OP_BUSY_POLL   = 8'hf0; // busy_poll_cmd
	localparam logic [7:0] OP_EN_OFFLINE  = 8'hc6; // Offline mode entry
	localparam logic [7:0] OP_EN_TRANSP   = 8'h74; // Transparent mode entry
	localparam logic [7:0] OP_MODE_EXIT   = 8'h26; // config_mode_exit_cmd
	localparam logic [7:0] OP_STREAM_LOAD = 8'h7a; // stream_load_cmd
	localparam logic [7:0] OP_USER_WR     = 8'hc2; // user_code_write_cmd
	localparam logic [7:0] OP_BULK_ERASE  = 8'h0e; // array_bulk_erase_cmd
	localparam logic [7:0] OP_SET_DONE    = 8'h5e; // set_completion_flag_cmd
	localparam logic [7:0] OP_SET_SECURE  = 8'hce; // set_security_bit_cmd
	localparam logic [7:0] OP_ADDR_INIT   = 8'h46; // frame_addr_init_cmd
	localparam logic [7:0] OP_ADDR_LOAD   = 8'hb4; // frame_addr_load_cmd
	localparam logic [7:0] OP_FRAME_WR    = 8'h82; // frame_write_inc_cmd
	localparam logic [7:0] OP_PACKED_WR   = 8'hb8; // packed_frame_write_cmd
	localparam logic [7:0] OP_FRAME_RD    = 8'h6a; // frame_read_inc_cmd
	localparam logic [7:0] OP_DICT_LOAD   = 8'h02; // unpack_dictionary_cmd
	localparam logic [7:0] OP_CTRL1_WR    = 8'h22; // ctrl_first_write_cmd
	localparam logic [7:0] OP_CTRL1_RD    = 8'h20; // ctrl_first_read_cmd
	localparam logic [7:0] OP_CTRL2_WR    = 8'h23; // ctrl_second_write_cmd
	localparam logic [7:0] OP_CTRL2_RD    = 8'h21; // ctrl_second_read_cmd
	localparam logic [7:0] OP_SUM_CLEAR   = 8'h3b; // frame_sum_clear_cmd
	localparam logic [7:0] OP_SUM_RD      = 8'h60; // frame_sum_read_cmd
	localparam logic [7:0] OP_UPSET_WR    = 8'ha2; // upset_sum_write_cmd
	localparam logic [7:0] OP_UPSET_RD    = 8'ha4; // upset_sum_read_cmd
	localparam logic [7:0] OP_PASS_BURN   = 8'hf1; // passkey_burn_cmd
	localparam logic [7:0] OP_PASS_RD     = 8'hf2; // passkey_read_cmd
	localparam logic [7:0] OP_PASS_UNLOCK = 8'hbc; // passkey_unlock_cmd
	localparam logic [7:0] OP_KEY_BURN    = 8'hf3; // secret_key_burn_cmd
	localparam logic [7:0] OP_KEY_RD      = 8'hf4; // secret_key_read_cmd
	localparam logic [7:0] OP_BUS_TARGET  = 8'hf6; // setup_bus_target_cmd
	localparam logic [7:0] OP_BUS_WR      = 8'h72; // setup_bus_write_cmd
	localparam logic [7:0] OP_BUS_RD      = 8'hf7; // setup_bus_read_cmd

	// ****************************************************************
	// Wishbone register map, fields and reset values
	// ****************************************************************
	localparam logic [7:0] ADR_CTRL      = 8'h00; // Control, read/write
	localparam logic [7:0] ADR_STATUS    = 8'h04; // Status, read only
	localparam logic [7:0] ADR_USERCODE  = 8'h08; // User code, read only
	localparam logic [7:0] ADR_FRAMEADDR = 8'h0c; // Frame address, read only
	localparam int         CTL_LINK_EN   = 0;     // Link accepted when set
	localparam int         CTL_PW_PROT   = 1;     // Sticky passkey protection
	localparam int         CTL_KEY_LOCK  = 2;     // Sticky key activation
	localparam logic [2:0] CTRL_RST      = 3'h1;  // Link enabled out of reset

	// ****************************************************************
	// Sizes, reset values and timing
	// ****************************************************************
	localparam int          MEM_DEPTH = 16;      // Frames held, one word each
	localparam logic [15:0] FA_INIT   = 16'h0000; // Frame address start
	localparam logic [2:0]  SYNC_RST  = 3'h2;    // Pin sync reset {din,sel,clk}
	localparam int          MCLK_NS   = 40;      // Block clock period
	localparam int          ERASE_NS  = 2000;    // Least erase busy time
	localparam int          BURN_NS   = 1000;    // Least fuse burn busy time
	localparam logic [7:0]  ERASE_CYC =
		8'((ERASE_NS + MCLK_NS - 1) / MCLK_NS);
	localparam logic [7:0]  BURN_CYC  =
		8'((BURN_NS + MCLK_NS - 1) / MCLK_NS);

	// Access mode and link framing phase
	typedef enum logic [1:0] {MD_NONE, MD_OFFLINE, MD_TRANSP} scd_mode_t;
	typedef enum logic [1:0] {LK_IDLE, LK_OPCODE, LK_OPND, LK_DATA} scd_phase_t;

endpackage

// [scd_decoder.sv]
// Serial configuration command decoder with its Wishbone status port
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module scd_decoder
	import scd_pkg::*;
(
	input  wire logic        mclk,       // Block clock
	input  wire logic        rst_b,      // Asynchronous reset
	input  wire logic [7:0]  adr_i,      // Wishbone byte address
	input  wire logic [31:0] dat_i,      // Wishbone write data
	input  wire logic [3:0]  sel_i,      // Wishbone byte lanes
	input  wire logic        we_i,       // Wishbone write
	input  wire logic        stb_i,      // Wishbone strobe
	input  wire logic        cyc_i,      // Wishbone cycle
	output logic      [31:0] dat_o,      // Wishbone read data
	output logic             ack_o,      // Wishbone acknowledge
	input  wire logic        linkClk,    // Host serial clock
	input  wire logic        linkSel_b,  // Host select, active low
	input  wire logic        linkDin,    // Host to device data
	output logic             linkDout,   // Device to host data
	output logic             linkDoutOe, // Drive enable of linkDout
	output logic             doneOut,    // Completion flag
	output logic             busyOut     // Command still executing
);
	import scd_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [2:0]      syncFf [3];       // Three-stage pin synchronisers
	logic            pinLvl [3];       // Settled pin levels, one per sync
	logic [2:0]      pinChg;           // Settled level changes this cycle
	scd_phase_t      phase;            // Framing phase of the transaction
	scd_mode_t       mode;             // Access mode
	logic [2:0]      bitCnt;           // Bit within the current byte
	logic [6:0]      rxSh;             // Bits gathered so far
	logic [7:0]      opcode;           // Opcode of this transaction
	logic [23:0]     operand;          // Operand field
	logic [1:0]      opndCnt;          // Operand byte count
	logic [4:0]      dataIdx;          // Data byte index, wraps
	logic [255:0]    rxBig;            // Received data history
	logic [7:0]      txSh;             // Outgoing byte
	logic [7:0]      next_tx;          // Byte to send next
	logic [2:0]      ctrlReg;          // Software control bits
	logic            securityBit;      // Security flag
	logic [31:0]     userCode;         // User code register
	logic [15:0]     frameAddr;        // Frame address
	logic [15:0]     frameSum;         // Frame checksum
	logic [31:0]     upsetSum;         // Upset detection checksum
	logic [31:0]     ctrlOne;          // First control register
	logic [31:0]     ctrlTwo;          // Second control register
	logic [127:0]    passkey;          // Fuse-held passkey
	logic            pwBurnt;          // Passkey fuse already blown
	logic            unlocked;         // Passkey matched
	logic [255:0]    secretKey;        // Fuse-held cipher key
	logic [7:0]      dict [4];         // Expansion dictionary
	logic [7:0]      initTarget;       // Setup bus target
	logic [15:0]     initAddr;         // Setup bus address
	logic [31:0]     initData;         // Setup bus data latch
	logic            streaming;        // Stream load in progress
	logic [7:0]      busyCnt;          // Remaining busy cycles
	logic [31:0]     mem [MEM_DEPTH];  // Configuration frames
	logic            rxBit;            // Data bit at this clock rise
	logic            byteEnd;          // Last bit of a byte taken
	logic            opndEnd;          // Last operand byte taken
	logic            dataEnd;          // A data byte taken
	logic [7:0]      inByte;           // Data byte after expansion
	logic [31:0]     wordIn;           // Last four data bytes
	logic            mayWrite;         // Writes to the array allowed
	logic            linkEnd;          // Select released

	// Most significant first byte pick from a word
	function automatic logic [7:0] pickByte(logic [31:0] w, logic [1:0] i);
		return w[{~i, 3'h7} -: 8];
	endfunction

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// Only the second and third stages are compared, so the first stage
	// never reaches logic while it may still be metastable.
	generate
		for (genvar g = 0; g < 3; g++)
		begin : gSync
			always_ff @(posedge mclk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					syncFf[g] <= {3{SYNC_RST[g]}};
					pinLvl[g] <= SYNC_RST[g];
				end
				else
				begin
					syncFf[g] <= {syncFf[g][1:0],
						g == 0 ? linkClk : (g == 1 ? linkSel_b : linkDin)};
					if (syncFf[g][1] == syncFf[g][2])
						pinLvl[g] <= syncFf[g][2];
				end
			end
			assign pinChg[g] = (syncFf[g][1] == syncFf[g][2]) &&
				(syncFf[g][2] != pinLvl[g]);
		end
	endgenerate

	// Data is stable across the rise, so the settled level is the bit
	assign rxBit    = pinLvl[2];
	assign linkEnd  = pinLvl[1] && phase != LK_IDLE;
	assign byteEnd  = pinChg[0] && syncFf[0][2] && !pinLvl[1] &&
		phase != LK_IDLE && bitCnt == 3'h7;
	assign opndEnd  = byteEnd && phase == LK_OPND && opndCnt == 2'h2;
	assign dataEnd  = byteEnd && phase == LK_DATA;
	// Dictionary codes have the top bit set; others pass as literals
	assign inByte   = (opcode == OP_PACKED_WR && rxSh[6]) ?
		dict[{rxSh[0], rxBit}] : {rxSh, rxBit};
	assign wordIn   = {rxBig[23:0], inByte};
	assign mayWrite = mode != MD_NONE &&
		(!ctrlReg[CTL_PW_PROT] || unlocked);

	// ****************************************************************
	// Transaction framing
	// ****************************************************************
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			phase   <= LK_IDLE;
			bitCnt  <= '0;
			rxSh    <= '0;
			opcode  <= '0;
			operand <= '0;
			opndCnt <= '0;
			dataIdx <= '0;
			rxBig   <= '0;
		end
		else if (linkEnd)
			phase <= LK_IDLE;        // Select released ends everything
		else
		begin
			unique case (phase)
				LK_IDLE:
				begin
					bitCnt <= '0;
					if (!pinLvl[1] && ctrlReg[CTL_LINK_EN])
						phase <= LK_OPCODE;
				end
				LK_OPCODE, LK_OPND, LK_DATA:
				begin
					if (pinChg[0] && syncFf[0][2])
					begin
						bitCnt <= bitCnt + 3'h1;
						rxSh   <= {rxSh[5:0], rxBit};
					end
					if (byteEnd && phase == LK_OPCODE)
					begin
						opcode  <= {rxSh, rxBit};
						opndCnt <= '0;
						phase   <= LK_OPND;
					end
					if (byteEnd && phase == LK_OPND)
					begin
						operand <= {operand[15:0], rxSh, rxBit};
						opndCnt <= opndCnt + 2'h1;
						dataIdx <= '0;
						if (opndCnt == 2'h2)
							phase <= LK_DATA;
					end
					if (dataEnd)
					begin
						rxBig   <= {rxBig[247:0], inByte};
						dataIdx <= dataIdx + 5'h1;
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// Command effects
	// ****************************************************************
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode <= MD_NONE;
			{doneOut, securityBit, pwBurnt, unlocked, streaming} <= '0;
			{userCode, upsetSum, ctrlOne, ctrlTwo, initData} <= '0;
			frameAddr <= FA_INIT;
			{frameSum, initAddr, initTarget, busyCnt} <= '0;
			passkey   <= '0;
			secretKey <= '0;
			for (int i = 0; i < 4; i++)
				dict[i] <= '0;
			for (int i = 0; i < MEM_DEPTH; i++)
				mem[i] <= '0;
		end
		else
		begin
			// Busy counts down on its own; long jobs just reload it
			if (busyCnt != 8'h00)
				busyCnt <= busyCnt - 8'h01;
			if (linkEnd)
				streaming <= 1'b0;
			if (opndEnd)
			begin
				unique case (opcode)
					OP_EN_OFFLINE: mode <= MD_OFFLINE;
					OP_EN_TRANSP:  mode <= MD_TRANSP;
					OP_MODE_EXIT:
					begin
						mode      <= MD_NONE;
						streaming <= 1'b0;
						busyCnt   <= '0;
					end
					OP_BULK_ERASE:
						if (mayWrite)
						begin
							busyCnt <= ERASE_CYC;
							if ({operand[15:0], rxSh, rxBit} == 24'h0 ||
								rxBit)
								for (int i = 0; i < MEM_DEPTH; i++)
									mem[i] <= '0;
							if (rxSh[0])
								userCode <= '0;
						end
					OP_SET_DONE:
						if (mode != MD_NONE)
							doneOut <= 1'b1;
					OP_SET_SECURE:
						if (mode != MD_NONE)
							securityBit <= 1'b1;
					OP_STREAM_LOAD:
						if (mayWrite)
						begin
							streaming <= 1'b1;
							frameAddr <= FA_INIT;
						end
					OP_ADDR_INIT: frameAddr <= FA_INIT;
					OP_SUM_CLEAR: frameSum  <= '0;
					OP_BUS_TARGET:
					begin
						initTarget <= operand[15:8];
						initAddr   <= {operand[7:0], rxSh, rxBit};
					end
					default: ;
				endcase
			end
			if (dataEnd)
			begin
				unique case (opcode)
					OP_USER_WR:
						if (dataIdx == 5'h3)
							userCode <= wordIn;
					OP_ADDR_LOAD:
						if (dataIdx == 5'h1)
							frameAddr <= wordIn[15:0];
					OP_FRAME_WR, OP_PACKED_WR, OP_STREAM_LOAD:
						if (dataIdx[1:0] == 2'h3 && mayWrite &&
							(opcode != OP_STREAM_LOAD || streaming))
						begin
							mem[frameAddr[3:0]] <= wordIn;
							frameAddr <= frameAddr + 16'h1;
							frameSum  <= {frameSum[14:0], frameSum[15]} ^
								wordIn[31:16] ^ wordIn[15:0];
						end
					OP_FRAME_RD:
						if (dataIdx[1:0] == 2'h2)
							frameAddr <= frameAddr + 16'h1;
					OP_DICT_LOAD:
						dict[dataIdx[1:0]] <= inByte;
					OP_CTRL1_WR:
						if (dataIdx == 5'h3)
							ctrlOne <= wordIn;
					OP_CTRL2_WR:
						if (dataIdx == 5'h3)
							ctrlTwo <= wordIn;
					OP_UPSET_WR:
						if (dataIdx == 5'h3)
							upsetSum <= wordIn;
					OP_PASS_BURN:
						if (dataIdx == 5'hf && !pwBurnt)
						begin
							passkey <= {rxBig[119:0], inByte};
							pwBurnt <= 1'b1;
							busyCnt <= BURN_CYC;
						end
					OP_PASS_UNLOCK:
						if (dataIdx == 5'hf)
							unlocked <= {rxBig[119:0], inByte} == passkey;
					OP_KEY_BURN:
						if (dataIdx == 5'h1f)
						begin
							secretKey <= {rxBig[247:0], inByte};
							busyCnt   <= BURN_CYC;
						end
					OP_BUS_WR:
						if (dataIdx == 5'h3)
							initData <= wordIn;
					default: ;
				endcase
			end
		end
	end

	// Busy flag seen by the poll command and the status register
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			busyOut <= 1'b0;
		else
			busyOut <= busyCnt != 8'h00 || streaming;
	end

	// ****************************************************************
	// Read answers
	// ****************************************************************
	// The byte is chosen one byte early, at the end of the previous one
	always_comb
	begin
		logic [4:0] n;
		n = (phase == LK_OPND) ? 5'h0 : dataIdx + 5'h1;
		unique case (opcode)
			OP_BUSY_POLL:  next_tx = {7'h0, busyOut};
			OP_CTRL1_RD:   next_tx = pickByte(ctrlOne, n[1:0]);
			OP_CTRL2_RD:   next_tx = pickByte(ctrlTwo, n[1:0]);
			OP_SUM_RD:     next_tx = pickByte({frameSum, 16'h0}, n[1:0]);
			OP_UPSET_RD:   next_tx = pickByte(upsetSum, n[1:0]);
			OP_FRAME_RD:
				next_tx = pickByte(mem[frameAddr[3:0]], n[1:0]);
			OP_BUS_RD:     next_tx = pickByte(initData, n[1:0]);
			// Protection blanks the readback rather than refusing it
			OP_PASS_RD:    next_tx = ctrlReg[CTL_PW_PROT] ? 8'h00 :
				passkey[{~n[3:0], 3'h7} -: 8];
			OP_KEY_RD:     next_tx = ctrlReg[CTL_KEY_LOCK] ? 8'h00 :
				secretKey[{~n, 3'h7} -: 8];
			default:       next_tx = 8'h00;
		endcase
	end

	// Outgoing shifter, bits change on the falling link clock
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			txSh       <= '0;
			linkDout   <= 1'b0;
			linkDoutOe <= 1'b0;
		end
		else
		begin
			linkDoutOe <= phase == LK_DATA && !pinLvl[1];
			if (byteEnd && phase != LK_OPCODE)
				txSh <= next_tx;
			else if (pinChg[0] && !syncFf[0][2])
			begin
				linkDout <= txSh[7];
				txSh     <= {txSh[6:0], 1'b0};
			end
		end
	end

	// ****************************************************************
	// Wishbone slave
	// ****************************************************************
	// Answers one cycle after the request; unmapped reads return zero
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ack_o   <= 1'b0;
			dat_o   <= '0;
			ctrlReg <= CTRL_RST;
		end
		else
		begin
			ack_o <= cyc_i && stb_i && !ack_o;
			if (cyc_i && stb_i && !ack_o)
			begin
				if (we_i && sel_i[0] && adr_i == ADR_CTRL)
					// Protection bits are sticky: software cannot undo them
					ctrlReg <= {ctrlReg[2:1] | dat_i[2:1], dat_i[0]};
				unique case (adr_i)
					ADR_CTRL:      dat_o <= {29'h0, ctrlReg};
					ADR_STATUS:    dat_o <= {24'h0, 1'b0, busyOut,
						unlocked, pwBurnt, securityBit, doneOut, mode};
					ADR_USERCODE:  dat_o <= userCode;
					ADR_FRAMEADDR: dat_o <= {16'h0, frameAddr};
					default:       dat_o <= '0;
				endcase
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	a_mode_exit: assert property (opndEnd && opcode == OP_MODE_EXIT
		|=> mode == MD_NONE && !streaming) else $error("exit failed");
	a_erase_busy: assert property (opndEnd && opcode == OP_BULK_ERASE &&
		mayWrite |=> busyCnt == ERASE_CYC ##1 busyOut [*4])
		else $error("erase not busy");
	a_done_gate: assert property (opndEnd && opcode == OP_SET_DONE &&
		mode == MD_NONE |=> doneOut == $past(doneOut))
		else $error("done set outside mode");
	a_secure_set: assert property (opndEnd && opcode == OP_SET_SECURE &&
		mode != MD_NONE |=> securityBit) else $error("no security");
	a_user_code: assert property (dataEnd && opcode == OP_USER_WR &&
		dataIdx == 5'h3 |=> userCode == $past(wordIn))
		else $error("usercode lost");
	a_addr_init: assert property (opndEnd && opcode == OP_ADDR_INIT
		|=> frameAddr == FA_INIT) else $error("address not reset");
	a_addr_inc: assert property (dataEnd && opcode == OP_FRAME_WR &&
		dataIdx[1:0] == 2'h3 && mayWrite
		|=> frameAddr == $past(frameAddr) + 16'h1)
		else $error("address not advanced");
	a_sum_clear: assert property (opndEnd && opcode == OP_SUM_CLEAR
		|=> frameSum == 16'h0) else $error("sum not cleared");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held");

	c_stream: cover property (opndEnd && opcode == OP_STREAM_LOAD && mayWrite);
	c_frame_wr: cover property (dataEnd && opcode == OP_FRAME_WR && mayWrite);
	c_unlock: cover property (!unlocked ##1 unlocked);

endmodule // scd_decoder

// [scd_host.sv]
// Host model: mode 0 serial master on the decoder's link pins
`timescale 1ns/1ps
module scd_host
(
	input  wire logic mclk,      // Bench clock, paces the link
	output logic      linkClk,   // Serial clock, still between frames
	output logic      linkSel_b, // Select, active low
	output logic      linkDin,   // Data to the device
	input  wire logic linkDout   // Data from the device
);
	// ****************************************************************
	// Idle levels and one frame
	// ****************************************************************
	initial
	begin
		linkClk = 1'b0;
		linkSel_b = 1'b1;
		linkDin = 1'b0;
	end

	// Bytes MSB first, 8 mclk a bit; read data taken late in the high
	// half, since the device only moves linkDout after a settled fall
	task automatic xfer(input logic [63:0] tx, input int n,
		output logic [31:0] rx);
		rx = 32'h0;
		@(posedge mclk) linkSel_b <= 1'b0;
		for (int i = 8 * n - 1; i >= 0; i--)
		begin
			linkDin <= tx[i];
			repeat (4) @(posedge mclk);
			linkClk <= 1'b1;
			repeat (4) @(posedge mclk);
			rx = {rx[30:0], linkDout};
			linkClk <= 1'b0;
		end
		repeat (4) @(posedge mclk);
		linkSel_b <= 1'b1;
		// Released line shows the inverse, never a stale level
		linkDin <= ~linkDin;
		repeat (4) @(posedge mclk);
	endtask
endmodule // scd_host

// [tb_scd_decoder.sv]
// Bench: table of link commands, then frame, user code and erase cases
`timescale 1ns/1ps
module tb_scd_decoder;
	import scd_pkg::*;
	typedef struct {logic [63:0] tx; int n; logic [6:0] st;} scd_row_t;
	logic        mclk, rst_b, we, stb, cyc, ack, linkClk, linkSel_b;
	logic        linkDin, linkDout, linkDoutOe, doneOut, busyOut;
	logic [7:0]  adr;
	logic [31:0] wdat, rdat, q;
	int          miscompares = 0, total_checks = 0, k;
	// Command, length, expected status after it
	scd_row_t    rows [6] = '{'{64'h5e000000, 4, 7'h00},
		'{64'hab000000, 4, 7'h00}, '{64'hc6000000, 4, 7'h01},
		'{64'hce000000, 4, 7'h09}, '{64'h5e000000, 4, 7'h0d},
		'{64'h26000000, 4, 7'h0c}};

	scd_decoder i_dut (.mclk(mclk), .rst_b(rst_b), .adr_i(adr),
		.dat_i(wdat), .sel_i(4'hf), .we_i(we), .stb_i(stb), .cyc_i(cyc),
		.dat_o(rdat), .ack_o(ack), .linkClk(linkClk),
		.linkSel_b(linkSel_b), .linkDin(linkDin), .linkDout(linkDout),
		.linkDoutOe(linkDoutOe), .doneOut(doneOut), .busyOut(busyOut));
	scd_host i_host (.mclk(mclk), .linkClk(linkClk),
		.linkSel_b(linkSel_b), .linkDin(linkDin), .linkDout(linkDout));

	// ****************************************************************
	// Clock, checks and bus cycles
	// ****************************************************************
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic final_report;
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Classic cycle held until ack is sampled; bounded wait
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int t;
		@(posedge mclk);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		t = 0;
		do
		begin
			@(posedge mclk);
			t++;
		end
		while (ack !== 1'b1 && t < 20);
		r = rdat;
		{cyc, stb} <= 2'b00;
		if (ack !== 1'b1)
		begin
			miscompares++;
			final_report();
		end
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		{rst_b, cyc, stb, we, adr, wdat} = '0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		check({29'h0, doneOut, busyOut, linkDoutOe}, 32'h0);
		repeat (4) @(posedge mclk);
		wb(1'b0, 8'h10, 32'h0, q);
		check(q, 32'h0);
		foreach (rows[i])
		begin
			i_host.xfer(rows[i].tx, rows[i].n, q);
			wb(1'b0, ADR_STATUS, 32'h0, q);
			check(q & 32'h7f, {25'h0, rows[i].st});
			check({31'h0, doneOut}, {31'h0, rows[i].st[2]});
		end
		// Mode entry first, as the host must
		i_host.xfer(64'hc6000000, 4, q);
		i_host.xfer(64'h82000000_12345678, 8, q);
		wb(1'b0, ADR_FRAMEADDR, 32'h0, q);
		check(q, 32'h1);
		i_host.xfer(64'h46000000, 4, q);
		wb(1'b0, ADR_FRAMEADDR, 32'h0, q);
		check(q, {16'h0, FA_INIT});
		i_host.xfer(64'h6a000000_00000000, 8, q);
		check(q, 32'h12345678);
		wb(1'b0, ADR_FRAMEADDR, 32'h0, q);
		check(q, 32'h1);
		// Frame sum after one word: both halves folded, then cleared
		i_host.xfer(64'h60000000_00000000, 8, q);
		check(q, 32'h444c0000);
		i_host.xfer(64'h3b000000, 4, q);
		i_host.xfer(64'h60000000_00000000, 8, q);
		check(q, 32'h0);
		i_host.xfer(64'hb4000000_0005, 6, q);
		wb(1'b0, ADR_FRAMEADDR, 32'h0, q);
		check(q, 32'h5);
		i_host.xfer(64'hc2000000_cafef00d, 8, q);
		wb(1'b0, ADR_USERCODE, 32'h0, q);
		check(q, 32'hcafef00d);
		// Erase of the user code: busy first, then polled down
		i_host.xfer(64'h0e000002, 4, q);
		check({31'h0, busyOut}, 32'h1);
		k = 0;
		do
		begin
			wb(1'b0, ADR_STATUS, 32'h0, q);
			k++;
		end
		while (q[6] !== 1'b0 && k < 200);
		check({31'h0, q[6]}, 32'h0);
		wb(1'b0, ADR_USERCODE, 32'h0, q);
		check(q, 32'h0);
		// Protection on without unlock: frame write must be refused
		wb(1'b1, ADR_CTRL, 32'h3, q);
		wb(1'b0, ADR_CTRL, 32'h0, q);
		check(q, 32'h3);
		i_host.xfer(64'h82000000_0badf00d, 8, q);
		wb(1'b0, ADR_FRAMEADDR, 32'h0, q);
		check(q, 32'h5);
		// Reset in mid-run: flags, sticky bits and bus answer cleared
		rst_b <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		check({28'h0, ack, doneOut, busyOut, linkDoutOe}, 32'h0);
		repeat (4) @(posedge mclk);
		wb(1'b0, ADR_CTRL, 32'h0, q);
		check(q, {29'h0, CTRL_RST});
		wb(1'b0, ADR_STATUS, 32'h0, q);
		check(q, 32'h0);
		final_report();
	end
endmodule // tb_scd_decoder
